// ---- shared/dtc_pkg.sv ----
package dtc_pkg;
  // ==========================================================
  // register indexes: byte address is four times the index
  localparam logic [3:0] DTC_IDX_MODE = 4'h0;
  localparam logic [3:0] DTC_IDX_CTRL = 4'h1;
  localparam logic [3:0] DTC_IDX_CLK  = 4'h2;
  localparam logic [3:0] DTC_IDX_T0L  = 4'h3;
  localparam logic [3:0] DTC_IDX_T0H  = 4'h4;
  localparam logic [3:0] DTC_IDX_T1L  = 4'h5;
  localparam logic [3:0] DTC_IDX_T1H  = 4'h6;
  localparam logic [3:0] DTC_IDX_STAT = 4'h7;
  localparam logic [3:0] DTC_IDX_MASK = 4'h8;
  localparam logic [3:0] DTC_IDX_BAD  = 4'hf;
  // ==========================================================
  // field positions
  localparam int DTC_MSEL0 = 0;
  localparam int DTC_CT0   = 2;
  localparam int DTC_GATE0 = 3;
  localparam int DTC_MSEL1 = 4;
  localparam int DTC_CT1   = 6;
  localparam int DTC_GATE1 = 7;
  localparam int DTC_RUN0  = 4;
  localparam int DTC_OVF0  = 5;
  localparam int DTC_RUN1  = 6;
  localparam int DTC_OVF1  = 7;
  localparam int DTC_TB0   = 3;
  localparam int DTC_TB1   = 4;
  localparam logic [7:0] DTC_CLK_WMASK = 8'h18;
  // ==========================================================
  // reset values
  localparam logic [7:0] DTC_RST_MODE = 8'h00;
  localparam logic [7:0] DTC_RST_CTRL = 8'h00;
  localparam logic [7:0] DTC_RST_CLK  = 8'h00;
  localparam logic [1:0] DTC_RST_MASK = 2'h0;
  // ==========================================================
  // machine cycle timing
  localparam logic [1:0] DTC_PH_C1      = 2'h0;
  localparam logic [1:0] DTC_PH_C3      = 2'h2;
  localparam logic [1:0] DTC_PH_C4      = 2'h3;
  localparam logic [1:0] DTC_PRESC_LAST = 2'h2;
  localparam logic [1:0] DTC_RESP_OKAY  = 2'h0;
  localparam logic [1:0] DTC_RESP_SLV   = 2'h2;
  typedef enum logic [1:0] {DTC_M13, DTC_M16, DTC_M8R, DTC_MSPLIT} dtc_mode_e;
endpackage

// ---- shared/dtc_cnt_if.sv ----
`timescale 1ns/1ps
interface dtc_cnt_if;
  import dtc_pkg::*;
  dtc_mode_e  mode;
  logic       low_inc;
  logic       high_inc;
  logic       wr_low;
  logic       wr_high;
  logic [7:0] wdata;
  logic [7:0] low;
  logic [7:0] high;
  logic       ovf_low;
  logic       ovf_high;
  modport ctl (output mode, low_inc, high_inc, wr_low, wr_high, wdata,
               input low, high, ovf_low, ovf_high);
  modport cnt (input mode, low_inc, high_inc, wr_low, wr_high, wdata,
               output low, high, ovf_low, ovf_high);
endinterface

// ---- logic/dtc_counter.sv ----
`timescale 1ns/1ps
module dtc_counter import dtc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  dtc_cnt_if.cnt   bus
);
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
  } dtc_cnt_s;
  dtc_cnt_s st;
  dtc_cnt_s next_st;
  logic     ovf_low;
  logic     ovf_high;

  always_comb begin
    next_st = st;
    ovf_low = 1'b0;
    ovf_high = 1'b0;
    case (bus.mode)
      DTC_M13: if (bus.low_inc) begin
        // upper three low bits stay out of the count
        next_st.low[4:0] = st.low[4:0] + 5'h01;
        if (st.low[4:0] == 5'h1f) begin
          next_st.high = st.high + 8'h01;
          ovf_low = (st.high == 8'hff);
        end
      end
      DTC_M16: if (bus.low_inc) begin
        {next_st.high, next_st.low} = {st.high, st.low} + 16'h0001;
        ovf_low = ({st.high, st.low} == 16'hffff);
      end
      DTC_M8R: if (bus.low_inc) begin
        next_st.low = (st.low == 8'hff) ? st.high : st.low + 8'h01;
        ovf_low = (st.low == 8'hff);
      end
      DTC_MSPLIT: begin
        if (bus.low_inc) begin
          next_st.low = st.low + 8'h01;
          ovf_low = (st.low == 8'hff);
        end
        if (bus.high_inc) begin
          next_st.high = st.high + 8'h01;
          ovf_high = (st.high == 8'hff);
        end
      end
      default: ;
    endcase
    // software load beats a same-cycle count
    if (bus.wr_low) next_st.low = bus.wdata;
    if (bus.wr_high) next_st.high = bus.wdata;
  end

  always_ff @(posedge clk) begin
    if (rst) st <= '0;
    else st <= next_st;
  end

  assign bus.low = st.low;
  assign bus.high = st.high;
  assign bus.ovf_low = ovf_low;
  assign bus.ovf_high = ovf_high;

  reload_hold_a: assert property (@(posedge clk) disable iff (rst)
    (bus.mode == DTC_M8R && bus.low_inc && st.low == 8'hff && !bus.wr_low && !bus.wr_high)
    |=> (st.low == $past(st.high) && st.high == $past(st.high)))
    else $error("auto reload did not copy upper byte");
  wrap_13_a: assert property (@(posedge clk) disable iff (rst)
    (bus.mode == DTC_M13 && bus.low_inc && st.high == 8'hff && st.low[4:0] == 5'h1f
     && !bus.wr_low && !bus.wr_high) |-> ovf_low ##1 (st.high == 8'h00 && st.low[4:0] == 5'h00))
    else $error("13 bit count did not wrap to zero");
endmodule

// ---- logic/dtc_top.sv ----
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - timer rate is clock/12 or clock/4
// - reset clears both time-base select bits
// - count pin sampled at fourth phase
// - count updates in third phase, next cycle
// - function select bits 2 and 6
// - four modes per timer via mode pair
// - mode 0 is 13-bit, prescale five bits
// - mode 0 wraps past 1FFFh, sets flag
// - count only when run and gate allow; timer 1 ignores its run bit while timer 0 is split
// - mode 1 counts 16 bits, flags rollover
// - mode 2 low byte reloads from upper
// - set flag requests an interrupt
// - mode 3 freezes timer 1, splits timer 0
// - split upper byte takes timer 1 controls
// - vectoring clears the overflow flag
module dtc_top import dtc_pkg::*; (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        COUNT_INPUT_ZERO,
  input  wire logic        COUNT_INPUT_ONE,
  input  wire logic        EXT_GATE_PIN0,
  input  wire logic        EXT_GATE_PIN1,
  input  wire logic        VECTOR_ACK0,
  input  wire logic        VECTOR_ACK1,
  output logic             TIMER0_OVERFLOW_FLAG,
  output logic             TIMER1_OVERFLOW_FLAG,
  output logic             IRQ
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] phase;
    logic [1:0] presc;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [1:0] sample;
    logic [1:0] pend;
    logic [7:0] tmode;
    logic [7:0] tctrl;
    logic [7:0] cctrl;
    logic [1:0] status;
    logic [1:0] mask;
    logic       irq;
    logic       awready;
    logic       wready;
    logic       aw_have;
    logic       w_have;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic       wstrb0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } dtc_top_s;

  dtc_top_s   st;
  dtc_top_s   next_st;
  dtc_mode_e  mode0;
  dtc_mode_e  mode1;
  logic       t0_split;
  logic       at_c3;
  logic       presc_end;
  logic       inc0;
  logic       inc0_high;
  logic       inc1;
  logic       ovf0_evt;
  logic       ovf1_evt;
  logic       do_wr;
  logic       wr_en;
  logic [3:0] widx;
  logic [3:0] ridx;
  logic [7:0] rd_val;

  dtc_cnt_if cif[2] ();

  // ==========================================================
  // helpers
  function automatic logic [3:0] dtc_decode(input logic [7:0] a);
    dtc_decode = DTC_IDX_BAD;
    if (a[1:0] == 2'h0 && a[7:2] <= {2'h0, DTC_IDX_MASK}) dtc_decode = a[5:2];
  endfunction

  // one count step: run bit, gate, then clock tick or pin edge
  function automatic logic dtc_step(input logic run,
                                    input logic gate_on,
                                    input logic gate_pin,
                                    input logic counter_fn,
                                    input logic fast,
                                    input logic pend,
                                    input logic pend_end);
    dtc_step = run & (!gate_on | gate_pin) & (counter_fn ? pend : (fast | pend_end));
  endfunction

  // ==========================================================
  // timer control
  assign mode0 = dtc_mode_e'(st.tmode[DTC_MSEL0 +: 2]);
  assign mode1 = dtc_mode_e'(st.tmode[DTC_MSEL1 +: 2]);
  assign t0_split = (mode0 == DTC_MSPLIT);
  assign at_c3 = (st.phase == DTC_PH_C3);
  assign presc_end = (st.presc == DTC_PRESC_LAST);

  assign inc0 = at_c3 & dtc_step(st.tctrl[DTC_RUN0], st.tmode[DTC_GATE0],
                                 st.sync2[2], st.tmode[DTC_CT0],
                                 st.cctrl[DTC_TB0], st.pend[0], presc_end);
  // split upper byte: clock ticks only, timer 1 run bit, no gate
  assign inc0_high = at_c3 & t0_split &
                     dtc_step(st.tctrl[DTC_RUN1], 1'b0, 1'b0, 1'b0,
                              st.cctrl[DTC_TB0], 1'b0, presc_end);
  // timer 1 loses its run bit to the split timer, and mode 3 freezes it
  assign inc1 = at_c3 & (mode1 != DTC_MSPLIT) &
                dtc_step(t0_split | st.tctrl[DTC_RUN1], st.tmode[DTC_GATE1],
                         st.sync2[3], st.tmode[DTC_CT1],
                         st.cctrl[DTC_TB1], st.pend[1], presc_end);

  assign ovf0_evt = cif[0].ovf_low;
  assign ovf1_evt = t0_split ? cif[0].ovf_high : cif[1].ovf_low;

  assign do_wr = st.aw_have & st.w_have & !st.bvalid;
  assign wr_en = do_wr & st.wstrb0;
  assign widx = dtc_decode(st.awaddr);
  assign ridx = dtc_decode(S_AXI_ARADDR);

  assign cif[0].mode = mode0;
  assign cif[0].low_inc = inc0;
  assign cif[0].high_inc = inc0_high;
  assign cif[0].wr_low = wr_en & (widx == DTC_IDX_T0L);
  assign cif[0].wr_high = wr_en & (widx == DTC_IDX_T0H);
  assign cif[0].wdata = st.wdata;
  assign cif[1].mode = mode1;
  assign cif[1].low_inc = inc1;
  assign cif[1].high_inc = 1'b0;
  assign cif[1].wr_low = wr_en & (widx == DTC_IDX_T1L);
  assign cif[1].wr_high = wr_en & (widx == DTC_IDX_T1H);
  assign cif[1].wdata = st.wdata;

  for (genvar g = 0; g < 2; g++) begin : g_cnt
    dtc_counter u_cnt (
      .clk (MCLK),
      .rst (SRST),
      .bus (cif[g])
    );
  end

  // ==========================================================
  // read mux
  always_comb begin
    rd_val = 8'h00;
    case (ridx)
      DTC_IDX_MODE: rd_val = st.tmode;
      DTC_IDX_CTRL: rd_val = st.tctrl;
      DTC_IDX_CLK:  rd_val = st.cctrl;
      DTC_IDX_T0L:  rd_val = cif[0].low;
      DTC_IDX_T0H:  rd_val = cif[0].high;
      DTC_IDX_T1L:  rd_val = cif[1].low;
      DTC_IDX_T1H:  rd_val = cif[1].high;
      DTC_IDX_STAT: rd_val = {6'h00, st.status};
      DTC_IDX_MASK: rd_val = {6'h00, st.mask};
      default:      rd_val = 8'h00;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.sync1 = {EXT_GATE_PIN1, EXT_GATE_PIN0, COUNT_INPUT_ONE, COUNT_INPUT_ZERO};
    next_st.sync2 = st.sync1;
    next_st.phase = st.phase + 2'h1;
    if (st.phase == DTC_PH_C4) begin
      next_st.presc = presc_end ? 2'h0 : st.presc + 2'h1;
      next_st.sample = st.sync2[1:0];
      for (int i = 0; i < 2; i++) begin
        if (st.sample[i] && !st.sync2[i]) next_st.pend[i] = 1'b1;
      end
    end
    // an edge is spent at the next third phase, counted or not
    if (at_c3) next_st.pend = 2'h0;

    if (S_AXI_AWVALID && st.awready) begin
      next_st.aw_have = 1'b1;
      next_st.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && st.wready) begin
      next_st.w_have = 1'b1;
      next_st.wdata = S_AXI_WDATA[7:0];
      next_st.wstrb0 = S_AXI_WSTRB[0];
    end
    if (st.bvalid && S_AXI_BREADY) next_st.bvalid = 1'b0;
    if (do_wr) begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = (widx == DTC_IDX_BAD) ? DTC_RESP_SLV : DTC_RESP_OKAY;
      if (st.wstrb0) begin
        case (widx)
          DTC_IDX_MODE: next_st.tmode = st.wdata;
          DTC_IDX_CTRL: next_st.tctrl = st.wdata;
          DTC_IDX_CLK:  next_st.cctrl = st.wdata & DTC_CLK_WMASK;
          DTC_IDX_STAT: next_st.status = st.status & ~st.wdata[1:0];
          DTC_IDX_MASK: next_st.mask = st.wdata[1:0];
          default: ;
        endcase
      end
    end
    next_st.awready = !next_st.aw_have && !next_st.bvalid;
    next_st.wready = !next_st.w_have && !next_st.bvalid;

    if (st.rvalid && S_AXI_RREADY) next_st.rvalid = 1'b0;
    if (S_AXI_ARVALID && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_val;
      next_st.rresp = (ridx == DTC_IDX_BAD) ? DTC_RESP_SLV : DTC_RESP_OKAY;
    end
    next_st.arready = !next_st.rvalid;

    // clear by vectoring first, so a same-cycle overflow still sets
    if (VECTOR_ACK0) next_st.tctrl[DTC_OVF0] = 1'b0;
    if (VECTOR_ACK1) next_st.tctrl[DTC_OVF1] = 1'b0;
    if (ovf0_evt) begin
      next_st.tctrl[DTC_OVF0] = 1'b1;
      next_st.status[0] = 1'b1;
    end
    if (ovf1_evt) begin
      next_st.tctrl[DTC_OVF1] = 1'b1;
      next_st.status[1] = 1'b1;
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      st <= '0;
      st.tmode <= DTC_RST_MODE;
      st.tctrl <= DTC_RST_CTRL;
      st.cctrl <= DTC_RST_CLK;
      st.mask <= DTC_RST_MASK;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign S_AXI_AWREADY = st.awready;
  assign S_AXI_WREADY = st.wready;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_ARREADY = st.arready;
  assign S_AXI_RDATA = {24'h000000, st.rdata};
  assign S_AXI_RRESP = st.rresp;
  assign S_AXI_RVALID = st.rvalid;
  // flags go straight to the interrupt controller
  assign TIMER0_OVERFLOW_FLAG = st.tctrl[DTC_OVF0];
  assign TIMER1_OVERFLOW_FLAG = st.tctrl[DTC_OVF1];
  assign IRQ = st.irq;

  // ==========================================================
  // assertions
  default clocking dtc_cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);

  sequence s_fall0;
    st.phase == DTC_PH_C4 && st.sample[0] && !st.sync2[0];
  endsequence
  sequence s_fast0;
    (st.tctrl[DTC_RUN0] && !st.tmode[DTC_GATE0] && !st.tmode[DTC_CT0]
     && st.cctrl[DTC_TB0])[*4];
  endsequence

  tb_reset_a: assert property ($fell(SRST) |-> !st.cctrl[DTC_TB0] && !st.cctrl[DTC_TB1])
    else $error("time-base select not cleared by reset");
  phase_wrap_a: assert property (st.phase == DTC_PH_C4 |=> st.phase == DTC_PH_C1)
    else $error("machine cycle not four phases");
  slow_gap_a: assert property ((inc0 && !st.tmode[DTC_CT0] && !st.cctrl[DTC_TB0])
    |=> (!inc0 || st.cctrl[DTC_TB0] || st.tmode[DTC_CT0]) [*8])
    else $error("slow time base counted too soon");
  fast_rate_a: assert property ((inc0 ##1 s_fast0) |-> inc0)
    else $error("fast time base missed a tick");
  edge_count_a: assert property ((s_fall0 ##3 (st.tctrl[DTC_RUN0] && !st.tmode[DTC_GATE0]
    && st.tmode[DTC_CT0])) |-> inc0)
    else $error("pin edge not counted in next cycle");
  c3_only_a: assert property ((cif[0].low != $past(cif[0].low) && !$past(cif[0].wr_low))
    |-> $past(st.phase) == DTC_PH_C3)
    else $error("count changed outside third phase");
  gate_block_a: assert property ((st.tmode[DTC_GATE0] && !st.sync2[2]) |-> !inc0)
    else $error("counted while gate pin low");
  ovf_set_a: assert property (ovf0_evt |=> st.tctrl[DTC_OVF0] && st.status[0])
    else $error("overflow did not set flag");
  ovf_clear_a: assert property ((VECTOR_ACK0 && !ovf0_evt && !wr_en)
    |=> !TIMER0_OVERFLOW_FLAG)
    else $error("vectoring did not clear flag");
  irq_level_a: assert property (IRQ == |(st.status & st.mask))
    else $error("interrupt level disagrees with status");
  split_flag_a: assert property ((t0_split && cif[0].ovf_high) |=> TIMER1_OVERFLOW_FLAG)
    else $error("split upper byte did not set timer 1 flag");
  t1_frozen_a: assert property ((mode1 == DTC_MSPLIT && !cif[1].wr_low)
    |=> cif[1].low == $past(cif[1].low))
    else $error("timer 1 counted in mode 3");
endmodule

// ---- tb/dtc_far_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// far side: count pins and interrupt controller
module dtc_far_model import dtc_pkg::*; #(
  parameter int HOLD = 12
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [3:0] npulse,
  input  wire logic       sel,
  input  wire logic [1:0] ack_en,
  input  wire logic       flag0,
  input  wire logic       flag1,
  output logic            pin0,
  output logic            pin1,
  output logic            busy,
  output logic            ack0,
  output logic            ack1
);
  // each level held three machine cycles: pulse period stays at 24 clocks
  initial begin
    pin0 = 1'b1;
    pin1 = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < int'(npulse); i++) begin
          repeat (HOLD) @(posedge clk);
          if (sel) pin1 <= 1'b0;
          else pin0 <= 1'b0;
          repeat (HOLD) @(posedge clk);
          pin0 <= 1'b1;
          pin1 <= 1'b1;
        end
        repeat (HOLD) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
  // vectors only to enabled sources, one pulse per request
  always @(posedge clk) begin
    if (rst) begin
      ack0 <= 1'b0;
      ack1 <= 1'b0;
    end else begin
      ack0 <= ack_en[0] && flag0 && !ack0;
      ack1 <= ack_en[1] && flag1 && !ack1;
    end
  end
endmodule

// ---- tb/tb_dual_timer_counter.sv ----
`timescale 1ns/1ps
module tb_dual_timer_counter;
  import dtc_pkg::*;
  logic        MCLK, SRST, awv, wv, bready, arv, rready, gate0, gate1, go, sel;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, seed;
  logic [3:0]  wstrb, npulse;
  logic [1:0]  bresp, rresp, r, ack_en;
  logic        awready, wready, bvalid, arready, rvalid, cnt0, cnt1, busy;
  logic        ack0, ack1, flag0, flag1, irq;
  logic [15:0] v;
  logic [7:0]  r8;
  int          n_fail, num_checks;

  dtc_top uut (.MCLK(MCLK), .SRST(SRST),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .COUNT_INPUT_ZERO(cnt0), .COUNT_INPUT_ONE(cnt1), .EXT_GATE_PIN0(gate0),
    .EXT_GATE_PIN1(gate1), .VECTOR_ACK0(ack0), .VECTOR_ACK1(ack1),
    .TIMER0_OVERFLOW_FLAG(flag0), .TIMER1_OVERFLOW_FLAG(flag1), .IRQ(irq));
  dtc_far_model far (.clk(MCLK), .rst(SRST), .go(go), .npulse(npulse), .sel(sel),
    .ack_en(ack_en), .flag0(flag0), .flag1(flag1), .pin0(cnt0), .pin1(cnt1),
    .busy(busy), .ack0(ack0), .ack1(ack1));

  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic logic [7:0] ad(input logic [3:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  function automatic int ticks(input int fast, input int cyc);
    return fast ? cyc / 4 : cyc / 12;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input logic [31:0] got, input int exp, input int tol);
    num_checks++;
    if ($isunknown(got) || int'(got) < exp - tol || int'(got) > exp + tol) begin
      n_fail++;
      $display("FAIL %0t got %0d expected about %0d", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // bus master: no cycle count assumed, bounded by timeout
  task automatic axw(input logic [7:0] a, input logic [31:0] dw, input logic [3:0] s);
    @(posedge MCLK);
    awaddr <= a;
    wdata <= dw;
    wstrb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge MCLK);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge MCLK);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge MCLK);
      if (arready) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] dw);
    axw(ad(i), dw, 4'h1);
    chk(32'(r), 32'(DTC_RESP_OKAY));
  endtask
  task automatic rd(input logic [3:0] i);
    axr(ad(i));
    chk(32'(r), 32'(DTC_RESP_OKAY));
  endtask
  task automatic set_t(input int t, input logic [15:0] x);
    wr(t ? DTC_IDX_T1L : DTC_IDX_T0L, 32'(x[7:0]));
    wr(t ? DTC_IDX_T1H : DTC_IDX_T0H, 32'(x[15:8]));
  endtask
  task automatic get_t(input int t);
    rd(t ? DTC_IDX_T1L : DTC_IDX_T0L);
    v[7:0] = d[7:0];
    rd(t ? DTC_IDX_T1H : DTC_IDX_T0H);
    v[15:8] = d[7:0];
  endtask
  task automatic wait_flag(input int t);
    int k;
    k = 0;
    while ((t ? flag1 : flag0) !== 1'b1 && k < 2000) begin
      @(posedge MCLK);
      k++;
    end
    chk(32'(k < 2000), 32'h1);
    // stop the timer but keep its flag up for the vectoring check
    wr(DTC_IDX_CTRL, 32'h1 << (DTC_OVF0 + 2 * t));
  endtask
  task automatic ack(input int t);
    chk(32'(t ? flag1 : flag0), 32'h1);
    ack_en[t] <= 1'b1;
    repeat (4) @(posedge MCLK);
    chk(32'(t ? flag1 : flag0), 32'h0);
    ack_en[t] <= 1'b0;
    wr(DTC_IDX_STAT, 32'h1 << t);
  endtask
  // ==========================================================
  // watchdog
  initial begin
    repeat (60000) @(posedge MCLK);
    n_fail++;
    wrap_up;
  end
  // ==========================================================
  // main sequence
  initial begin
    {awv, wv, bready, arv, rready, gate0, gate1, go, sel, ack_en} = '0;
    {awaddr, araddr, wdata, wstrb, npulse} = '0;
    seed = 32'h57718604;
    SRST = 1'b1;
    repeat (6) @(posedge MCLK);
    SRST <= 1'b0;
    @(posedge MCLK);
    rd(DTC_IDX_MODE);
    chk(d, 32'(DTC_RST_MODE));
    rd(DTC_IDX_CLK);
    chk(d, 32'(DTC_RST_CLK));
    axr(ad(DTC_IDX_BAD));
    chk({d[29:0], r}, 32'(DTC_RESP_SLV));
    axw(ad(DTC_IDX_BAD), 32'h5a, 4'h1);
    chk(32'(r), 32'(DTC_RESP_SLV));
    axw(ad(DTC_IDX_T0L), 32'h5a, 4'h0);
    chk(32'(r), 32'(DTC_RESP_OKAY));
    rd(DTC_IDX_T0L);
    chk(d, 32'h0);
    wr(DTC_IDX_MASK, 32'h3);
    for (int t = 0; t < 2; t++) begin
      // both time bases, 244 clocks between run and stop commits
      for (int f = 0; f < 2; f++) begin
        wr(DTC_IDX_CLK, 32'(f) << (DTC_TB0 + t));
        wr(DTC_IDX_MODE, 32'h1 << (4 * t));
        set_t(t, 16'h0);
        wr(DTC_IDX_CTRL, 32'h1 << (DTC_RUN0 + 2 * t));
        repeat (240) @(posedge MCLK);
        wr(DTC_IDX_CTRL, 32'h0);
        get_t(t);
        chk_near(32'(v), ticks(f, 244), 2);
      end
      set_t(t, 16'hfffe);
      wr(DTC_IDX_CTRL, 32'h1 << (DTC_RUN0 + 2 * t));
      wait_flag(t);
      rd(DTC_IDX_STAT);
      chk(32'(d[t]), 32'h1);
      wr(DTC_IDX_MASK, 32'h0);
      chk(32'(irq), 32'h0);
      wr(DTC_IDX_MASK, 32'h3);
      chk(32'(irq), 32'h1);
      ack(t);
      chk(32'(irq), 32'h0);
      // mode 0: upper three bits of the low byte set, two ticks to wrap
      wr(DTC_IDX_MODE, 32'h0);
      set_t(t, 16'hfffe);
      wr(DTC_IDX_CTRL, 32'h1 << (DTC_RUN0 + 2 * t));
      wait_flag(t);
      get_t(t);
      chk(32'(v[15:8]), 32'h0);
      chk_near(32'(v[4:0]), 1, 2);
      chk(32'(v[7:5]), 32'h7);
      ack(t);
      seed = lfsr(seed);
      r8 = {1'b0, seed[6:0]};
      wr(DTC_IDX_MODE, 32'h2 << (4 * t));
      set_t(t, {r8, 8'hfe});
      wr(DTC_IDX_CTRL, 32'h1 << (DTC_RUN0 + 2 * t));
      wait_flag(t);
      get_t(t);
      chk(32'(v[15:8]), 32'(r8));
      chk_near(32'(v[7:0]), int'(r8) + 1, 2);
      ack(t);
      // gate pin low holds the count, high lets it run
      wr(DTC_IDX_MODE, 32'h9 << (4 * t));
      set_t(t, 16'h0);
      wr(DTC_IDX_CTRL, 32'h1 << (DTC_RUN0 + 2 * t));
      repeat (200) @(posedge MCLK);
      get_t(t);
      chk(32'(v), 32'h0);
      if (t) gate1 <= 1'b1;
      else gate0 <= 1'b1;
      repeat (200) @(posedge MCLK);
      wr(DTC_IDX_CTRL, 32'h0);
      get_t(t);
      chk_near(32'(v), ticks(1, 200), 8);
      // counter function: exact count of random falling edges
      wr(DTC_IDX_MODE, 32'h5 << (4 * t));
      set_t(t, 16'h0);
      wr(DTC_IDX_CTRL, 32'h1 << (DTC_RUN0 + 2 * t));
      seed = lfsr(seed);
      npulse <= 4'(seed[2:0]) + 4'h1;
      sel <= 1'(t);
      go <= 1'b1;
      @(posedge MCLK);
      go <= 1'b0;
      @(posedge MCLK);
      while (busy === 1'b1) @(posedge MCLK);
      repeat (20) @(posedge MCLK);
      wr(DTC_IDX_CTRL, 32'h0);
      get_t(t);
      chk(32'(v), 32'(npulse));
    end
    // split mode: upper byte of timer 0 on timer 1 run bit and flag
    wr(DTC_IDX_CLK, 32'h18);
    wr(DTC_IDX_MODE, 32'h33);
    set_t(0, 16'hfe00);
    set_t(1, 16'h1234);
    wr(DTC_IDX_CTRL, 32'h1 << DTC_RUN1);
    wait_flag(1);
    get_t(0);
    chk(32'(v[7:0]), 32'h0);
    chk_near(32'(v[15:8]), 1, 2);
    get_t(1);
    chk(32'(v), 32'h1234);
    ack(1);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(DTC_IDX_T0L + 4'(i % 4), 32'(seed[7:0]));
      rd(DTC_IDX_T0L + 4'(i % 4));
      chk(d, 32'(seed[7:0]));
    end
    wrap_up;
  end
endmodule
